// >>> hdl/dcr_regbank.sv
/*
 * Serial control port and register bank of a dual channel converter.
 * Assumes serial pins are synchronous to clk_in and the serial clock
 * half period spans at least three system clocks.
 */
// Notes on behaviour
// - Addresses 0x08 to 0x18 and 0x30 are shadows; writes alone change nothing.
// - Writing 0x01 to 0xFF copies all shadows to active registers together.
// - The transfer bit clears itself once the copy is done.
// - Local registers have one copy per channel, chosen by 0x05 bits 0 and 1.
// - With both channel bits set, a local write reaches both copies.
// - Reads with both channel bits set return the channel A copy.
// - Global registers and bits ignore the channel select bits.
// - Port setup mirrors bit order at 6/1, soft reset at 5/2, bits 4,3 one.
// - A frame starts with a 16-bit instruction: read flag, length, address.
// - Serial data shifts most significant bit first until bit order changes.
// - Reset loads the registers with their default values.
`timescale 1ns/100ps
`default_nettype none

module dcr_regbank
    import dcr_pkg::*;
#(
    parameter logic [7:0]              ID_CODE     = 8'h5a,  // Arbitrary identity value
    parameter logic [1:0]              SPEED_GRADE = 2'h0,   // Grade field value
    parameter logic [SHADOW_COUNT-1:0] LOCAL_MASK  = SHADOW_LOCAL
)
(
    input  wire logic clk_in,        // System clock, 25 MHz
    input  wire logic reset_n_in,    // Async reset, active low
    input  wire logic sclk_in,       // Serial clock
    input  wire logic csb_in,        // Chip select, active low
    input  wire logic sdio_in,       // Serial data pin level
    output logic      sdio_out,      // Serial data drive value
    output logic      sdio_oe_out,   // Serial data drive enable
    output dcr_bank_t active_a_out,  // Active bank, channel A
    output dcr_bank_t active_b_out   // Active bank, channel B
);

    // ************************************************************
    // State
    // ************************************************************
    dcr_state_e state;
    dcr_state_e next_state;
    logic [3:0]  bit_cnt;
    logic [3:0]  next_bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] next_shift;
    dcr_instr_s  instr;
    dcr_instr_s  next_instr;
    logic [12:0] addr;
    logic [12:0] next_addr;
    logic [1:0]  byte_cnt;
    logic [1:0]  next_byte_cnt;
    logic [7:0]  tx_byte;
    logic [7:0]  next_tx;
    logic        next_sdio;
    logic        next_oe;
    logic        lsb_first;
    logic        next_lsb;
    logic        soft_reset;
    logic        next_soft;
    logic [1:0]  chan_sel;
    logic [1:0]  next_chan;
    logic        xfer;
    logic        next_xfer;
    logic        sclk_q;

    logic        rise;
    logic        fall;
    logic [15:0] shifted;
    logic [15:0] word;
    logic        wr_now;
    logic [7:0]  wr_byte;
    dcr_wr_s     mem_wr;
    logic [5:0]  map;
    logic        map_hit;
    logic        map_local;
    logic        rd_chan_b;
    logic [7:0]  mem_rd_data;
    logic [7:0]  port_rd;
    logic [7:0]  rd_value;
    logic [7:0]  rd_ordered;

    assign rise      = sclk_in & ~sclk_q;
    assign fall      = ~sclk_in & sclk_q;
    assign shifted   = {shift_in[14:0], sdio_in};
    assign word      = lsb_first ? {dcr_rev8(shifted[7:0]), dcr_rev8(shifted[15:8])} : shifted;
    assign map       = dcr_shadow_map(addr);
    assign map_hit   = map[5];
    assign map_local = map_hit && LOCAL_MASK[map[4:0]];

    // ************************************************************
    // Read path
    // ************************************************************
    assign port_rd   = {1'b0, lsb_first, soft_reset, 2'b11, soft_reset, lsb_first, 1'b0};
    assign rd_chan_b = map_local && (chan_sel == CHAN_B_ONLY);

    always_comb begin
        rd_value = 8'h00;
        if (map_hit) begin
            rd_value = mem_rd_data;
        end else if (addr == ADDR_PORT_SETUP) begin
            rd_value = port_rd;
        end else if (addr == ADDR_PART_ID) begin
            rd_value = ID_CODE;
        end else if (addr == ADDR_SPEED_GRADE) begin
            rd_value = {2'b00, SPEED_GRADE, 4'h0};
        end else if (addr == ADDR_CHAN_SEL) begin
            rd_value = {6'h00, chan_sel};
        end else if (addr == ADDR_XFER) begin
            rd_value = {7'h00, xfer};
        end
    end

    assign rd_ordered = lsb_first ? dcr_rev8(rd_value) : rd_value;

    // ************************************************************
    // Frame sequencing and register writes
    // ************************************************************
    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_shift    = shift_in;
        next_instr    = instr;
        next_addr     = addr;
        next_byte_cnt = byte_cnt;
        next_tx       = tx_byte;
        next_sdio     = sdio_out;
        next_oe       = 1'b0;
        next_lsb      = lsb_first;
        next_soft     = 1'b0;
        next_chan     = chan_sel;
        next_xfer     = 1'b0;
        wr_now        = 1'b0;
        wr_byte       = 8'h00;
        mem_wr        = '0;
        if (csb_in) begin
            next_state    = ST_IDLE;
            next_bit_cnt  = 4'h0;
            next_byte_cnt = 2'h0;
        end else begin
            case (state)
                ST_IDLE, ST_INSTR: begin
                    if (rise) begin
                        next_shift = shifted;
                        if (bit_cnt == INSTR_LAST_BIT) begin
                            next_instr   = dcr_instr_s'(word);
                            next_addr    = word[12:0];
                            next_state   = ST_DATA;
                            next_bit_cnt = 4'h0;
                        end else begin
                            next_bit_cnt = bit_cnt + 4'h1;
                            next_state   = ST_INSTR;
                        end
                    end
                end
                ST_DATA: begin
                    next_oe = instr.rd;
                    if (rise) begin
                        next_shift = shifted;
                        if (bit_cnt[2:0] == BYTE_LAST_BIT) begin
                            next_bit_cnt  = 4'h0;
                            wr_now        = !instr.rd;
                            wr_byte       = lsb_first ? dcr_rev8(shifted[7:0]) : shifted[7:0];
                            next_addr     = lsb_first ? addr + 13'h0001 : addr - 13'h0001;
                            next_byte_cnt = byte_cnt + 2'h1;
                            if (instr.len != LEN_STREAM && byte_cnt == instr.len) begin
                                next_state = ST_DONE;
                            end
                        end else begin
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end else if (fall && instr.rd) begin
                        if (bit_cnt == 4'h0) begin
                            next_tx   = rd_ordered;
                            next_sdio = rd_ordered[7];
                        end else begin
                            next_sdio = tx_byte[3'h7 - bit_cnt[2:0]];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (wr_now) begin
            if (map_hit) begin
                mem_wr.idx  = map[4:0];
                mem_wr.data = wr_byte;
                mem_wr.en   = map_local ? chan_sel : CHAN_BOTH;
            end else if (addr == ADDR_PORT_SETUP) begin
                next_lsb  = wr_byte[PS_LSB_HI] | wr_byte[PS_LSB_LO];
                next_soft = wr_byte[PS_SR_HI] | wr_byte[PS_SR_LO];
            end else if (addr == ADDR_CHAN_SEL) begin
                next_chan = wr_byte[1:0];
            end else if (addr == ADDR_XFER) begin
                next_xfer = wr_byte[XFER_BIT];
            end
        end
        if (soft_reset) begin
            next_lsb  = 1'b0;
            next_chan = CHAN_SEL_RESET;
            next_xfer = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state       <= ST_IDLE;
            bit_cnt     <= 4'h0;
            shift_in    <= 16'h0000;
            instr       <= '0;
            addr        <= 13'h0000;
            byte_cnt    <= 2'h0;
            tx_byte     <= 8'h00;
            sdio_out    <= 1'b0;
            sdio_oe_out <= 1'b0;
            lsb_first   <= PORT_SETUP_RESET[PS_LSB_HI];
            soft_reset  <= PORT_SETUP_RESET[PS_SR_HI];
            chan_sel    <= CHAN_SEL_RESET;
            xfer        <= 1'b0;
            sclk_q      <= 1'b0;
        end else begin
            state       <= next_state;
            bit_cnt     <= next_bit_cnt;
            shift_in    <= next_shift;
            instr       <= next_instr;
            addr        <= next_addr;
            byte_cnt    <= next_byte_cnt;
            tx_byte     <= next_tx;
            sdio_out    <= next_sdio;
            sdio_oe_out <= next_oe;
            lsb_first   <= next_lsb;
            soft_reset  <= next_soft;
            chan_sel    <= next_chan;
            xfer        <= next_xfer;
            sclk_q      <= sclk_in;
        end
    end

    // ************************************************************
    // Shadowed bank
    // ************************************************************
    dcr_shadow_mem u_mem (
        .clk_in       (clk_in),
        .reset_n_in   (reset_n_in),
        .init_in      (soft_reset),
        .wr_in        (mem_wr),
        .rd_idx_in    (map[4:0]),
        .rd_chan_b_in (rd_chan_b),
        .xfer_in      (xfer),
        .rd_data_out  (mem_rd_data),
        .active_a_out (active_a_out),
        .active_b_out (active_b_out)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking top_cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    xfer_start_a: assert property (wr_now && addr == ADDR_XFER && wr_byte[0] && !soft_reset |=> xfer)
        else $error("transfer write did not raise transfer bit");
    xfer_autoclear_a: assert property (xfer |=> !xfer ##1 !xfer)
        else $error("transfer bit did not clear");
    xfer_ignore_a: assert property (wr_now && addr == ADDR_XFER && !wr_byte[0] |=> !xfer)
        else $error("transfer started with bit 0 clear");
    local_copy_a: assert property (wr_now && map_local |-> mem_wr.en == chan_sel)
        else $error("local write reached wrong channel copy");
    global_write_a: assert property (wr_now && map_hit && !map_local |-> mem_wr.en == CHAN_BOTH)
        else $error("global write depended on channel select");
    read_chan_a: assert property (chan_sel == CHAN_BOTH |-> !rd_chan_b)
        else $error("both selected read did not use channel A");
    setup_layout_a: assert property (port_rd[4:3] == 2'b11 && port_rd[6] == port_rd[1]
                                     && port_rd[5] == port_rd[2] && !port_rd[7] && !port_rd[0])
        else $error("port setup layout broken");
    instr_length_a: assert property (state == ST_INSTR && rise && bit_cnt == INSTR_LAST_BIT && !csb_in
                                     |=> state == ST_DATA && bit_cnt == 4'h0 && addr == $past(word[12:0]))
        else $error("instruction phase not sixteen bits");
    msb_out_a: assert property (state == ST_DATA && instr.rd && fall && bit_cnt == 4'h0 && !lsb_first && !csb_in
                                |=> sdio_out == $past(rd_value[7]))
        else $error("first read bit not most significant");
    soft_defaults_a: assert property (soft_reset |=> !lsb_first && chan_sel == CHAN_SEL_RESET && !soft_reset)
        else $error("soft reset did not restore defaults");

    xfer_seen_c: cover property (wr_now && addr == ADDR_XFER ##1 xfer);
    both_write_c: cover property (wr_now && map_local && chan_sel == CHAN_BOTH);
    read_frame_c: cover property (state == ST_DATA && instr.rd && fall);
    lsb_write_c: cover property (lsb_first && wr_now);

endmodule : dcr_regbank

`default_nettype wire

// >>> hdl/dcr_pkg.sv
/*
 * Constants, types and helpers for the dual converter register bank.
 * Assumes a byte-wide serial control port with a 13-bit register address.
 */
package dcr_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [12:0] ADDR_PORT_SETUP   = 13'h0000;
    localparam logic [12:0] ADDR_PART_ID      = 13'h0001;
    localparam logic [12:0] ADDR_SPEED_GRADE  = 13'h0002;
    localparam logic [12:0] ADDR_CHAN_SEL     = 13'h0005;
    localparam logic [12:0] ADDR_XFER         = 13'h00ff;
    localparam logic [12:0] ADDR_SHADOW_LO    = 13'h0008;
    localparam logic [12:0] ADDR_SHADOW_HI    = 13'h0018;
    localparam logic [12:0] ADDR_SHADOW_EXTRA = 13'h0030;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          PS_LSB_HI        = 6;
    localparam int          PS_LSB_LO        = 1;
    localparam int          PS_SR_HI         = 5;
    localparam int          PS_SR_LO         = 2;
    localparam int          XFER_BIT         = 0;
    localparam logic [7:0]  PORT_SETUP_RESET = 8'h18;
    localparam logic [1:0]  CHAN_SEL_RESET   = 2'h3;
    localparam logic [1:0]  CHAN_A_ONLY      = 2'h1;
    localparam logic [1:0]  CHAN_B_ONLY      = 2'h2;
    localparam logic [1:0]  CHAN_BOTH        = 2'h3;
    localparam logic [1:0]  LEN_STREAM       = 2'h3;
    localparam logic [3:0]  INSTR_LAST_BIT   = 4'hf;
    localparam logic [2:0]  BYTE_LAST_BIT    = 3'h7;

    // ************************************************************
    // Shadowed bank: index 0..16 is 0x08..0x18, index 17 is 0x30
    // ************************************************************
    localparam int          SHADOW_COUNT = 18;
    localparam logic [4:0]  IDX_EXTRA    = 5'h11;
    typedef logic [SHADOW_COUNT-1:0][7:0] dcr_bank_t;
    localparam dcr_bank_t   SHADOW_RESET = {8'h00, 8'hc0, 112'h0, 8'h01, 8'h80};
    localparam logic [SHADOW_COUNT-1:0] SHADOW_LOCAL = 18'h00021;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA  = 2'b11,
        ST_DONE  = 2'b10
    } dcr_state_e;

    typedef struct packed {
        logic        rd;
        logic [1:0]  len;
        logic [12:0] addr;
    } dcr_instr_s;

    typedef struct packed {
        logic [1:0]  en;
        logic [4:0]  idx;
        logic [7:0]  data;
    } dcr_wr_s;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [5:0] dcr_shadow_map(input logic [12:0] addr);
        if (addr >= ADDR_SHADOW_LO && addr <= ADDR_SHADOW_HI) begin
            return {1'b1, 5'(addr - ADDR_SHADOW_LO)};
        end else if (addr == ADDR_SHADOW_EXTRA) begin
            return {1'b1, IDX_EXTRA};
        end
        return 6'h00;
    endfunction : dcr_shadow_map

    function automatic logic [7:0] dcr_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction : dcr_rev8

endpackage : dcr_pkg

// >>> hdl/dcr_shadow_mem.sv
/*
 * Shadow and active copies of the shadowed bank for channels A and B.
 * Assumes the caller gives channel write enables and a transfer strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module dcr_shadow_mem
    import dcr_pkg::*;
(
    input  wire logic      clk_in,        // System clock
    input  wire logic      reset_n_in,    // Async reset, active low
    input  wire logic      init_in,       // Soft reset to defaults
    input  wire dcr_wr_s   wr_in,         // Shadow write request
    input  wire logic [4:0] rd_idx_in,    // Read index
    input  wire logic      rd_chan_b_in,  // Read channel B copy
    input  wire logic      xfer_in,       // Copy shadow to active
    output logic [7:0]     rd_data_out,   // Registered read data
    output dcr_bank_t      active_a_out,  // Active bank, channel A
    output dcr_bank_t      active_b_out   // Active bank, channel B
);

    // ************************************************************
    // Storage
    // ************************************************************
    dcr_bank_t  shadow_a;
    dcr_bank_t  shadow_b;
    dcr_bank_t  next_shadow_a;
    dcr_bank_t  next_shadow_b;
    dcr_bank_t  next_active_a;
    dcr_bank_t  next_active_b;
    logic [7:0] next_rd_data;

    always_comb begin
        next_shadow_a = shadow_a;
        next_shadow_b = shadow_b;
        next_active_a = active_a_out;
        next_active_b = active_b_out;
        if (init_in) begin
            next_shadow_a = SHADOW_RESET;
            next_shadow_b = SHADOW_RESET;
            next_active_a = SHADOW_RESET;
            next_active_b = SHADOW_RESET;
        end else begin
            if (wr_in.en[0]) begin
                next_shadow_a[wr_in.idx] = wr_in.data;
            end
            if (wr_in.en[1]) begin
                next_shadow_b[wr_in.idx] = wr_in.data;
            end
            if (xfer_in) begin
                next_active_a = shadow_a;
                next_active_b = shadow_b;
            end
        end
        next_rd_data = 8'h00;
        if (rd_idx_in <= IDX_EXTRA) begin
            next_rd_data = rd_chan_b_in ? shadow_b[rd_idx_in] : shadow_a[rd_idx_in];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shadow_a     <= SHADOW_RESET;
            shadow_b     <= SHADOW_RESET;
            active_a_out <= SHADOW_RESET;
            active_b_out <= SHADOW_RESET;
            rd_data_out  <= 8'h00;
        end else begin
            shadow_a     <= next_shadow_a;
            shadow_b     <= next_shadow_b;
            active_a_out <= next_active_a;
            active_b_out <= next_active_b;
            rd_data_out  <= next_rd_data;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking mem_cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    active_stable_a: assert property (!xfer_in && !init_in |=> $stable(active_a_out) && $stable(active_b_out))
        else $error("active bank changed without transfer");
    active_copy_a: assert property (xfer_in && !init_in |=> active_a_out == $past(shadow_a)
                                    && active_b_out == $past(shadow_b))
        else $error("transfer did not copy shadow bank");

endmodule : dcr_shadow_mem

`default_nettype wire

// >>> sim/dcr_host_model.sv
/* Serial control host model: frames of one instruction and one or two data bytes.
   Assumes the bench resolves the data wire and calls frame(). */
`timescale 1ns/100ps
`default_nettype none

module dcr_host_model (
    input  wire logic       clk_in,      // System clock
    input  wire logic       sdio_in,     // Resolved data wire
    output var  logic       sclk_out,    // Serial clock
    output var  logic       csb_out,     // Chip select, active low
    output var  logic       sdio_out,    // Host data drive value
    output var  logic       sdio_oe_out, // Host data drive enable
    output var  logic       rd_stb_out,  // Read byte ready pulse
    output var  logic [7:0] rd_byte_out  // Read byte
);
    // ************************************************************
    // Frame engine, serial clock three clocks low and four clocks high per period
    // ************************************************************
    initial begin
        sclk_out = 1'b0;
        csb_out = 1'b1;
        sdio_out = 1'b0;
        sdio_oe_out = 1'b0;
        rd_stb_out = 1'b0;
        rd_byte_out = 8'h00;
    end

    task automatic frame(input logic rd, input logic [1:0] ln, input logic [12:0] addr,
                         input logic [15:0] wd, input logic lsb);
        logic [15:0] ins;
        logic [7:0]  rb;
        int          j;
        int          p;
        int          k;
        ins = {rd, ln, addr};
        rb = 8'h00;
        k = 0;
        @(posedge clk_in);
        csb_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        for (int i = 0; i < 24 + 8 * int'(ln); i++) begin
            j = (i < 16) ? i : (i - 16) % 8;
            k = (i < 16) ? 0 : int'(ln) - (i - 16) / 8;
            p = lsb ? j : ((i < 16) ? 15 : 7) - j;
            sclk_out <= 1'b0;
            sdio_out <= (i < 16) ? ins[p] : wd[8 * k + p];
            sdio_oe_out <= !(rd && i >= 16);
            repeat (3) @(posedge clk_in);
            if (rd && i >= 16) rb[p] = sdio_in;
            sclk_out <= 1'b1;
            @(posedge clk_in);
            if (rd && i == 15) sdio_oe_out <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        csb_out <= 1'b1;
        sclk_out <= 1'b0;
        sdio_oe_out <= 1'b0;
        rd_byte_out <= rb;
        rd_stb_out <= rd;
        @(posedge clk_in);
        rd_stb_out <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : frame
endmodule : dcr_host_model

`default_nettype wire

// >>> sim/dcr_regbank_tb.sv
/* Self-checking bench for the register bank, queued expectations.
   Assumes default shadow layout and local mask of the design. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module dcr_regbank_tb
    import dcr_pkg::*;
;
    logic       clk_in, reset_n_in, sclk, csb, h_out, h_oe, d_out, d_oe, rd_stb, a_stb, idle_t;
    logic [7:0] rd_byte, a_val, v0, v1, v2, exp_v;
    dcr_bank_t  act_a, act_b;
    logic [7:0] exp_q[$];
    int         err_total, tests_run;
    integer     seed;
    wire logic  sdio_w;

    // Undriven wire toggles so a stale level never passes
    assign sdio_w = d_oe ? d_out : (h_oe ? h_out : idle_t);

    dcr_regbank #(.ID_CODE(8'h6c), .SPEED_GRADE(2'h1)) u_dut ( // ID value is arbitrary
        .clk_in(clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk), .csb_in(csb), .sdio_in(sdio_w),
        .sdio_out(d_out), .sdio_oe_out(d_oe), .active_a_out(act_a), .active_b_out(act_b));

    dcr_host_model u_host (.clk_in(clk_in), .sdio_in(sdio_w), .sclk_out(sclk), .csb_out(csb),
        .sdio_out(h_out), .sdio_oe_out(h_oe), .rd_stb_out(rd_stb), .rd_byte_out(rd_byte));

    // ************************************************************
    // Clock, drivers, watcher, closing
    // ************************************************************
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in) idle_t <= (idle_t !== 1'b1);

    always @(posedge clk_in) begin
        if (rd_stb || a_stb) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK(rd_stb ? rd_byte : a_val, exp_v)
        end
    end

    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
        u_host.frame(1'b0, 2'b00, a, {8'h00, d}, lsb);
    endtask : wr

    task automatic wr2(input logic [12:0] a, input logic [15:0] d, input logic lsb);
        u_host.frame(1'b0, 2'b01, a, d, lsb);
    endtask : wr2

    task automatic rd(input logic [12:0] a, input logic [7:0] e, input logic lsb);
        exp_q.push_back(e);
        u_host.frame(1'b1, 2'b00, a, 16'h0000, lsb);
    endtask : rd

    task automatic act(input logic [7:0] g, input logic [7:0] e);
        exp_q.push_back(e);
        a_val <= g;
        a_stb <= 1'b1;
        @(posedge clk_in);
        a_stb <= 1'b0;
        @(posedge clk_in);
    endtask : act

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        repeat (40000) @(posedge clk_in);
        err_total++;
        complete_run();
    end

    initial begin
        seed = 32'hc31c22d7;
        reset_n_in = 1'b0;
        a_stb = 1'b0;
        a_val = 8'h00;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rd(ADDR_PORT_SETUP, PORT_SETUP_RESET, 1'b0);
        rd(ADDR_CHAN_SEL, {6'h00, CHAN_SEL_RESET}, 1'b0);
        wr(ADDR_PART_ID, 8'hff, 1'b0);
        rd(ADDR_PART_ID, 8'h6c, 1'b0);
        rd(ADDR_SPEED_GRADE, 8'h10, 1'b0);
        rd(13'h0003, 8'h00, 1'b0);
        act(act_a[0], 8'h80);
        act(act_b[16], 8'hc0);
        $display("test reset values done");
        v0 = 8'($random(seed)) | 8'h10;
        wr(13'h000b, v0, 1'b0);
        act(act_a[3], 8'h00);
        rd(13'h000b, v0, 1'b0);
        wr(ADDR_XFER, 8'h00, 1'b0);
        act(act_b[3], 8'h00);
        wr(ADDR_XFER, 8'h01, 1'b0);
        act(act_a[3], v0);
        rd(ADDR_XFER, 8'h00, 1'b0);
        $display("test transfer done");
        v1 = 8'($random(seed));
        v2 = ~v1;
        wr(ADDR_CHAN_SEL, 8'h01, 1'b0);
        wr(13'h0008, v1, 1'b0);
        wr(ADDR_CHAN_SEL, 8'h02, 1'b0);
        wr(13'h0008, v2, 1'b0);
        wr(13'h000b, v1, 1'b0);
        rd(13'h0008, v2, 1'b0);
        wr(ADDR_CHAN_SEL, 8'h03, 1'b0);
        rd(13'h0008, v1, 1'b0);
        wr(13'h000d, v0, 1'b0);
        wr(ADDR_XFER, 8'h01, 1'b0);
        act(act_a[0], v1);
        act(act_b[0], v2);
        act(act_a[5], v0);
        act(act_b[5], v0);
        act(act_a[3], v1);
        act(act_b[3], v1);
        $display("test channel select done");
        wr(ADDR_PORT_SETUP, 8'h42, 1'b0);
        rd(ADDR_PORT_SETUP, 8'h5a, 1'b1);
        wr(ADDR_CHAN_SEL, 8'h02, 1'b1);
        rd(ADDR_CHAN_SEL, 8'h02, 1'b1);
        wr2(13'h000e, {v1, v0}, 1'b1);
        rd(13'h000f, v0, 1'b1);
        wr(ADDR_PORT_SETUP, 8'h18, 1'b1);
        rd(ADDR_PORT_SETUP, 8'h18, 1'b0);
        wr2(13'h000c, {v0, v2}, 1'b0);
        rd(13'h000b, v2, 1'b0);
        rd(13'h000e, v1, 1'b0);
        $display("test bit order done");
        wr(ADDR_PORT_SETUP, 8'h24, 1'b0);
        rd(ADDR_PORT_SETUP, 8'h18, 1'b0);
        rd(ADDR_CHAN_SEL, 8'h03, 1'b0);
        rd(13'h000b, 8'h00, 1'b0);
        act(act_a[3], 8'h00);
        act(act_b[0], 8'h80);
        $display("test soft reset done");
        repeat (5) @(posedge clk_in);
        complete_run();
    end
endmodule : dcr_regbank_tb

`default_nettype wire
